// file: inc/addr_status_pkg.sv
`default_nettype none
package addr_status_pkg;
	// register offset from port base
	localparam logic [8:0] address_status_offset = 9'h119;
	// bit positions in the address status register
	localparam int cic_pos  = 7;
	localparam int atn_pos  = 6;
	localparam int serial_poll_mode_flag_pos = 5;
	localparam int listener_primary_addressed_flag_pos = 4;
	localparam int talker_primary_addressed_flag_pos = 3;
	localparam int la_pos   = 2;
	localparam int ta_pos   = 1;
	localparam int major_minor_select_pos = 0;
	localparam logic [7:0] address_status_reset = 8'h00;
	// gpib multiline commands (7 bit, atn asserted)
	localparam logic [6:0] cmd_spe = 7'h18;
	localparam logic [6:0] cmd_spd = 7'h19;
	localparam logic [6:0] cmd_unl = 7'h3f;
	localparam logic [6:0] cmd_unt = 7'h5f;
	// addressing modes
	localparam logic [1:0] adm_mode3 = 2'h3;
	localparam logic [1:0] adm_mode1 = 2'h1;
	// bus command groups
	localparam logic [1:0] grp_lag = 2'h1;
	localparam logic [1:0] grp_tag = 2'h2;
	localparam logic [1:0] grp_scg = 2'h3;
endpackage
`default_nettype wire

// file: src/pin_sync.sv
`default_nettype none
module pin_sync
	import addr_status_pkg::*;
#(
	parameter int width = 1
)(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic [width-1:0] pin_i,
	output logic      [width-1:0] level_o
);
	logic [width-1:0] s1_ff;
	logic [width-1:0] s2_ff;
	logic [width-1:0] s3_ff;
	logic [width-1:0] lvl_ff;
	logic [width-1:0] nxt_lvl;

	// a change counts once the second and third stages agree
	always_comb
	begin
		nxt_lvl = lvl_ff;
		for (int i = 0; i < width; i++)
		begin
			if (s2_ff[i] == s3_ff[i])
				nxt_lvl[i] = s2_ff[i];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			s1_ff  <= '1;
			s2_ff  <= '1;
			s3_ff  <= '1;
			lvl_ff <= '1;
		end
		else
		begin
			s1_ff  <= pin_i;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	assign level_o = lvl_ff;
endmodule
`default_nettype wire

// file: src/cmd_decode.sv
`default_nettype none
module cmd_decode
	import addr_status_pkg::*;
(
	input  wire logic [6:0] cmd_i,
	input  wire logic [4:0] my_addr_i,
	input  wire logic [4:0] minor_addr_i,
	input  wire logic       minor_en_i,
	output logic            my_listen_o,
	output logic            my_talk_o,
	output logic            other_talk_o,
	output logic            is_minor_o,
	output logic            is_secondary_o,
	output logic            is_spe_o,
	output logic            is_spd_o,
	output logic            is_unl_o,
	output logic            is_unt_o
);
	logic [1:0] grp;
	logic       hit_major;
	logic       hit_minor;

	always_comb
	begin
		grp            = cmd_i[6:5];
		hit_major      = (cmd_i[4:0] == my_addr_i);
		hit_minor      = minor_en_i && (cmd_i[4:0] == minor_addr_i);
		my_listen_o    = (grp == grp_lag) && (hit_major || hit_minor) && (cmd_i != cmd_unl);
		my_talk_o      = (grp == grp_tag) && (hit_major || hit_minor) && (cmd_i != cmd_unt);
		other_talk_o   = (grp == grp_tag) && !hit_major && !hit_minor && (cmd_i != cmd_unt);
		is_minor_o     = hit_minor && !hit_major;
		is_secondary_o = (grp == grp_scg);
		is_spe_o       = (cmd_i == cmd_spe);
		is_spd_o       = (cmd_i == cmd_spd);
		is_unl_o       = (cmd_i == cmd_unl);
		is_unt_o       = (cmd_i == cmd_unt);
	end
endmodule
`default_nettype wire

// file: src/address_status.sv
`default_nettype none
module address_status
	import addr_status_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [8:0] addr_i,
	input  wire logic       atn_n_i,
	input  wire logic       cmd_valid_i,
	input  wire logic [6:0] cmd_i,
	input  wire logic [4:0] my_addr_i,
	input  wire logic [4:0] my_sec_addr_i,
	input  wire logic [4:0] minor_addr_i,
	input  wire logic [1:0] adm_mode_i,
	input  wire logic       lon_i,
	input  wire logic       ton_i,
	input  wire logic       ctrl_active_i,
	input  wire logic       ctrl_standby_i,
	input  wire logic       local_message_reset_i,
	input  wire logic       chip_reset_i,
	input  wire logic       change_clr_i,
	output logic [7:0]      rdata_o,
	output logic            rvalid_o,
	output logic            address_change_flag_o
);
	// ****************************************
	// pin synchronisation and command decode
	// ****************************************
	logic atn_n;
	logic my_listen, my_talk, other_talk, is_minor, is_sec;
	logic is_spe, is_spd, is_unl, is_unt;
	logic ext_mode, mode3;

	pin_sync #(.width(1)) u_atn_sync (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.pin_i   (atn_n_i),
		.level_o (atn_n)
	);

	cmd_decode u_dec (
		.cmd_i          (cmd_i),
		.my_addr_i      (my_addr_i),
		.minor_addr_i   (minor_addr_i),
		.minor_en_i     (adm_mode_i[0]),
		.my_listen_o    (my_listen),
		.my_talk_o      (my_talk),
		.other_talk_o   (other_talk),
		.is_minor_o     (is_minor),
		.is_secondary_o (is_sec),
		.is_spe_o       (is_spe),
		.is_spd_o       (is_spd),
		.is_unl_o       (is_unl),
		.is_unt_o       (is_unt)
	);

	assign ext_mode = (adm_mode_i[1] == 1'b1);
	assign mode3    = (adm_mode_i == adm_mode3);

	// ****************************************
	// address state
	// ****************************************
	logic cic_ff, serial_poll_mode_flag_ff, listener_primary_addressed_flag_ff, talker_primary_addressed_flag_ff, la_ff, ta_ff, major_minor_select_ff, chg_ff;
	logic nxt_cic, nxt_serial_poll_mode_flag, nxt_listener_primary_addressed_flag, nxt_talker_primary_addressed_flag, nxt_la, nxt_ta, nxt_major_minor_select, nxt_chg;
	logic cmd_go, soft_rst, any_change;

	always_comb
	begin
		cmd_go   = cmd_valid_i && !atn_n;
		soft_rst = local_message_reset_i || chip_reset_i;
		// idle or addressed reads as not in charge
		nxt_cic  = ctrl_active_i || ctrl_standby_i;
		nxt_serial_poll_mode_flag = serial_poll_mode_flag_ff;
		nxt_listener_primary_addressed_flag = listener_primary_addressed_flag_ff;
		nxt_talker_primary_addressed_flag = talker_primary_addressed_flag_ff;
		nxt_la   = la_ff || lon_i;
		nxt_ta   = ta_ff || ton_i;
		nxt_major_minor_select = major_minor_select_ff;
		if (cmd_go)
		begin
			if (my_listen)
			begin
				if (ext_mode)
					nxt_listener_primary_addressed_flag = 1'b1;
				else
				begin
					nxt_la   = 1'b1;
					nxt_ta   = 1'b0;
					nxt_major_minor_select = is_minor;
				end
			end
			else if (is_unl)
				nxt_la = lon_i;
			if (my_talk)
			begin
				if (ext_mode)
					nxt_talker_primary_addressed_flag = 1'b1;
				else
				begin
					nxt_ta   = 1'b1;
					nxt_la   = lon_i;
					nxt_major_minor_select = is_minor;
				end
			end
			else if (is_unt || other_talk)
				nxt_ta = ton_i;
			if (is_sec && mode3)
			begin
				// secondary only counts right after our primary
				if (listener_primary_addressed_flag_ff && cmd_i[4:0] == my_sec_addr_i)
				begin
					nxt_la = 1'b1;
					nxt_ta = 1'b0;
				end
				if (talker_primary_addressed_flag_ff && cmd_i[4:0] == my_sec_addr_i)
					nxt_ta = 1'b1;
			end
			if (!my_listen && !is_sec)
				nxt_listener_primary_addressed_flag = 1'b0;
			if (!my_talk && !is_sec)
				nxt_talker_primary_addressed_flag = 1'b0;
			if (is_spe && (ta_ff || my_talk))
				nxt_serial_poll_mode_flag = 1'b1;
			if (is_spd)
				nxt_serial_poll_mode_flag = 1'b0;
		end
		if (!ta_ff && !nxt_ta)
			nxt_serial_poll_mode_flag = 1'b0;
		if (adm_mode_i == 2'h0)
			nxt_major_minor_select = 1'b0;
		if (soft_rst)
		begin
			nxt_serial_poll_mode_flag = 1'b0;
			nxt_listener_primary_addressed_flag = 1'b0;
		end
		if (chip_reset_i)
		begin
			nxt_la   = 1'b0;
			nxt_ta   = 1'b0;
			nxt_major_minor_select = 1'b0;
		end
		any_change = (nxt_cic != cic_ff) || (nxt_la != la_ff) ||
			(nxt_ta != ta_ff) || (nxt_major_minor_select != major_minor_select_ff);
		// set wins over software clear
		nxt_chg = (chg_ff && !change_clr_i) || (any_change && !(lon_i || ton_i));
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			cic_ff  <= 1'b0;
			serial_poll_mode_flag_ff <= 1'b0;
			listener_primary_addressed_flag_ff <= 1'b0;
			talker_primary_addressed_flag_ff <= 1'b0;
			la_ff   <= 1'b0;
			ta_ff   <= 1'b0;
			major_minor_select_ff <= 1'b0;
			chg_ff  <= 1'b0;
		end
		else
		begin
			cic_ff  <= nxt_cic;
			serial_poll_mode_flag_ff <= nxt_serial_poll_mode_flag;
			listener_primary_addressed_flag_ff <= nxt_listener_primary_addressed_flag;
			talker_primary_addressed_flag_ff <= nxt_talker_primary_addressed_flag;
			la_ff   <= nxt_la;
			ta_ff   <= nxt_ta;
			major_minor_select_ff <= nxt_major_minor_select;
			chg_ff  <= nxt_chg;
		end
	end

	// ****************************************
	// register read port
	// ****************************************
	logic [7:0] rdata_ff, nxt_rdata;
	logic       rvalid_ff, nxt_rvalid;
	logic [7:0] status;

	always_comb
	begin
		status           = address_status_reset;
		status[cic_pos]  = cic_ff;
		status[atn_pos]  = atn_n;
		status[serial_poll_mode_flag_pos] = serial_poll_mode_flag_ff;
		status[listener_primary_addressed_flag_pos] = listener_primary_addressed_flag_ff;
		status[talker_primary_addressed_flag_pos] = talker_primary_addressed_flag_ff;
		status[la_pos]   = la_ff;
		status[ta_pos]   = ta_ff;
		status[major_minor_select_pos] = major_minor_select_ff;
		// writes are ignored: the write strobe reaches no storage here
		nxt_rvalid = rd_i && !wr_i && (addr_i == address_status_offset);
		nxt_rdata  = nxt_rvalid ? status : 8'h00;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign rdata_o               = rdata_ff;
	assign rvalid_o              = rvalid_ff;
	assign address_change_flag_o = chg_ff;

	// ****************************************
	// checks
	// ****************************************
	// antecedents leave out chip reset, which overrides every set below except the talker primary flag, which it leaves alone
	chk_cic_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
		##1 cic_ff == $past(ctrl_active_i || ctrl_standby_i))
		else $error("controller bit wrong");
	chk_cic_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!ctrl_active_i && !ctrl_standby_i |=> !cic_ff)
		else $error("controller bit set while idle");
	chk_atn_live: assert property (@(posedge clk_i) disable iff (!rstn_i)
		nxt_rvalid |=> rdata_o[atn_pos] == $past(atn_n))
		else $error("attention bit not live");
	chk_serial_poll_mode_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && is_spe && ta_ff && !soft_rst && !chip_reset_i |=> serial_poll_mode_flag_ff)
		else $error("serial poll mode not set");
	chk_serial_poll_mode_flag_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(cmd_go && is_spd) || soft_rst |=> !serial_poll_mode_flag_ff)
		else $error("serial poll mode not cleared");
	chk_listener_primary_addressed_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && my_listen && ext_mode && !soft_rst |=> listener_primary_addressed_flag_ff)
		else $error("listen primary not set");
	chk_lsec_match: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && is_sec && mode3 && listener_primary_addressed_flag_ff && (cmd_i[4:0] == my_sec_addr_i)
		&& !chip_reset_i |=> la_ff)
		else $error("listen secondary missed");
	chk_listener_primary_addressed_flag_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
		soft_rst |=> !listener_primary_addressed_flag_ff)
		else $error("listen primary not cleared");
	chk_talker_primary_addressed_flag_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && my_talk && ext_mode && !soft_rst |=> talker_primary_addressed_flag_ff)
		else $error("talk primary not set");
	chk_tsec_match: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && is_sec && mode3 && talker_primary_addressed_flag_ff && (cmd_i[4:0] == my_sec_addr_i)
		&& !chip_reset_i |=> ta_ff)
		else $error("talk secondary missed");
	chk_la_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
		lon_i && !chip_reset_i |=> la_ff)
		else $error("listen only not listener");
	chk_la_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && my_listen && !ext_mode && !chip_reset_i |=> la_ff && !ta_ff)
		else $error("listen addressing wrong");
	chk_la_clr: assert property (@(posedge clk_i) disable iff (!rstn_i)
		chip_reset_i |=> !la_ff && !ta_ff)
		else $error("chip reset left address state");
	chk_ta_ton: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ton_i && !chip_reset_i && !(cmd_go && my_listen) |=> ta_ff)
		else $error("talk only not talker");
	chk_ta_unt: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_go && is_unt && !ton_i |=> !ta_ff)
		else $error("untalk left talker");
	chk_chg_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$changed(la_ff) && !$past(lon_i) && !$past(ton_i) |-> chg_ff)
		else $error("change flag missed");
	chk_reset_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> {cic_ff, serial_poll_mode_flag_ff, listener_primary_addressed_flag_ff, talker_primary_addressed_flag_ff, la_ff, ta_ff, major_minor_select_ff} == 7'h00)
		else $error("status not clear after reset");
	chk_wr_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_i |=> !rvalid_o)
		else $error("write answered");

	cov_listen: cover property (@(posedge clk_i) disable iff (!rstn_i) cmd_go && my_listen);
	cov_poll:   cover property (@(posedge clk_i) disable iff (!rstn_i) serial_poll_mode_flag_ff ##1 !serial_poll_mode_flag_ff);
	cov_ext:    cover property (@(posedge clk_i) disable iff (!rstn_i) listener_primary_addressed_flag_ff ##1 la_ff);
	cov_minor:  cover property (@(posedge clk_i) disable iff (!rstn_i) la_ff && major_minor_select_ff);
	cov_talk:   cover property (@(posedge clk_i) disable iff (!rstn_i) ton_i ##1 ta_ff);
endmodule
`default_nettype wire

// file: test/bus_ctrl_model.sv
`default_nettype none
// ****
// far-side bus controller
// ****
module bus_ctrl_model
(
	input  wire logic       clk_i,
	output logic            atn_n_o,
	output logic            cmd_valid_o,
	output logic [6:0]      cmd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		atn_n_o = 1'b1;
		cmd_valid_o = 1'b0;
		cmd_o = 7'h7f;
	end
	// attention settles 5 cycles ahead so the 3-stage synchroniser sees it
	task automatic send(input logic [6:0] c, input logic a);
		@(negedge clk_i);
		atn_n_o = !a;
		repeat (5) @(negedge clk_i);
		cmd_o = c;
		cmd_valid_o = 1'b1;
		@(negedge clk_i);
		cmd_valid_o = 1'b0;
		cmd_o = ~c;
	endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
`default_nettype none
module tb_top
	import addr_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i, rstn_i, rd_i, wr_i, lon_i, ton_i, ca, cs, local_message_reset, crst, cclr;
	logic        atn_n, cvld, rvalid_o, acf;
	logic [8:0]  addr_i;
	logic [6:0]  cmd;
	logic [4:0]  ma, sec;
	logic [1:0]  adm;
	logic [7:0]  rdata_o;
	logic [15:0] n;
	logic [15:0] exp_q[$];
	int          fail_count, checks;
	// ****
	// clock, design and partner
	// ****
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	bus_ctrl_model pm_u (.clk_i(clk_i), .atn_n_o(atn_n), .cmd_valid_o(cvld), .cmd_o(cmd));
	address_status dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .rd_i(rd_i), .wr_i(wr_i),
		.addr_i(addr_i), .atn_n_i(atn_n), .cmd_valid_i(cvld), .cmd_i(cmd),
		.my_addr_i(ma), .my_sec_addr_i(sec), .minor_addr_i(ma ^ 5'h01),
		.adm_mode_i(adm), .lon_i(lon_i), .ton_i(ton_i), .ctrl_active_i(ca),
		.ctrl_standby_i(cs), .local_message_reset_i(local_message_reset), .chip_reset_i(crst),
		.change_clr_i(cclr), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.address_change_flag_o(acf));
	// ****
	// tasks
	// ****
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// only a plain read at the status offset may answer
	task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] e, m);
		@(negedge clk_i);
		rd_i = !w;
		wr_i = w;
		addr_i = a;
		if (!w && a == address_status_offset)
			exp_q.push_back({m, e});
		@(negedge clk_i);
		rd_i = 1'b0;
		wr_i = 1'b0;
	endtask
	task automatic rs(input logic [7:0] e, m);
		bus(1'b0, address_status_offset, e, m);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_i);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask
	task automatic flag(input logic e);
		@(negedge clk_i);
		checks++;
		if (acf !== e)
		begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, acf, e);
		end
	endtask
	// ****
	// watcher: oldest note against each answer
	// ****
	always @(negedge clk_i)
	begin
		if (rvalid_o !== 1'b0)
		begin
			checks++;
			if (exp_q.size() == 0)
			begin
				fail_count++;
				$display("ERROR %0t got %h exp %h", $time, rvalid_o, 1'b0);
			end
			else
			begin
				n = exp_q.pop_front();
				if ((rdata_o & n[15:8]) !== (n[7:0] & n[15:8]))
				begin
					fail_count++;
					$display("ERROR %0t got %h exp %h", $time, rdata_o, n[7:0]);
				end
			end
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end
	// ****
	// main sequence
	// ****
	initial
	begin
		void'($urandom(37671));
		{rstn_i, rd_i, wr_i, lon_i, ton_i, ca, cs, local_message_reset, crst, cclr} = '0;
		addr_i = 9'h000;
		adm = 2'h0;
		ma = 5'($urandom_range(29, 0));
		sec = 5'($urandom_range(30, 0));
		repeat (3) @(negedge clk_i);
		rstn_i = 1'b1;
		rs(8'h40, 8'hff);
		bus(1'b1, address_status_offset, 8'h00, 8'h00);
		bus(1'b0, 9'h118, 8'h00, 8'h00);
		rs(8'h40, 8'hff);
		$display("test reset and read-only done");
		for (int i = 1; i < 5; i++)
		begin
			{ca, cs} = 2'(i);
			repeat (2) @(negedge clk_i);
			rs({i[1:0] != 2'h0, 7'h40}, 8'hff);
		end
		$display("test controller done");
		pulse(cclr);
		flag(1'b0);
		pm_u.send({grp_lag, ma}, 1'b1);
		rs(8'h04, 8'hff);
		flag(1'b1);
		pm_u.send({grp_tag, ma}, 1'b1);
		rs(8'h02, 8'hfb);
		pm_u.send(cmd_spe, 1'b1);
		rs(8'h22, 8'hfb);
		pm_u.send(cmd_spd, 1'b1);
		rs(8'h02, 8'hfb);
		pm_u.send({grp_lag, ma}, 1'b1);
		rs(8'h04, 8'hff);
		pm_u.send(cmd_unl, 1'b1);
		pm_u.send({grp_tag, ma}, 1'b0);
		rs(8'h40, 8'hff);
		$display("test basic addressing done");
		adm = adm_mode1;
		pm_u.send({grp_lag, ma ^ 5'h01}, 1'b1);
		rs(8'h05, 8'hff);
		pm_u.send({grp_tag, ma}, 1'b1);
		rs(8'h02, 8'hff);
		pulse(cclr);
		pm_u.send(cmd_unt, 1'b1);
		rs(8'h00, 8'hff);
		flag(1'b1);
		$display("test minor addressing done");
		adm = adm_mode3;
		pm_u.send({grp_lag, ma}, 1'b1);
		rs(8'h10, 8'h10);
		pm_u.send({grp_scg, sec}, 1'b1);
		rs(8'h04, 8'h04);
		pm_u.send({grp_tag, ma}, 1'b1);
		rs(8'h08, 8'h08);
		pm_u.send({grp_scg, sec}, 1'b1);
		rs(8'h02, 8'h02);
		pm_u.send(cmd_spe, 1'b1);
		pm_u.send({grp_lag, ma}, 1'b1);
		rs(8'h30, 8'h30);
		pulse(local_message_reset);
		rs(8'h00, 8'h30);
		pulse(crst);
		rs(8'h00, 8'hbf);
		$display("test extended addressing done");
		adm = 2'h0;
		pm_u.send(7'h7f, 1'b0);
		pulse(cclr);
		lon_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rs(8'h44, 8'hff);
		flag(1'b0);
		lon_i = 1'b0;
		pulse(crst);
		ton_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rs(8'h42, 8'hff);
		ton_i = 1'b0;
		$display("test listen and talk only done");
		for (int k = 0; k < 20 && exp_q.size() != 0; k++)
			@(negedge clk_i);
		if (exp_q.size() != 0)
			fail_count++;
		finish_test();
	end
endmodule
`default_nettype wire
